// file: audio_serial_tx_status_sequencer.sv
// Transmit controller of the serial audio port: registers, flags and framing.
module audio_serial_tx_status_sequencer #(
  parameter logic [7:0] HALF_DIV = tx_seq_pkg::HALF_DIV
) (
  // Clock and resets.
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        soft_rst_in,
  input  wire logic        stop_state_in,
  // Register port.
  input  wire logic [1:0]  addr_in,
  input  wire logic [23:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [23:0] rdata_out,
  // Interrupt request.
  output logic             irq_req_out,
  output logic      [7:0]  irq_vector_out,
  // Serial link.
  input  wire logic        bit_clk_in,
  input  wire logic        word_sel_in,
  output logic             bit_clk_out,
  output logic             bit_clk_oe_n_out,
  output logic             word_sel_out,
  output logic             word_sel_oe_n_out,
  output logic      [2:0]  serial_data_out
);
  logic [23:0]             ctrl_reg;
  logic [23:0]             hold_reg [tx_seq_pkg::NUM_TX];
  logic                    left_empty_reg;
  logic                    right_empty_reg;
  logic                    armed_reg;
  logic [2:0]              wr_mask_reg;
  tx_seq_pkg::tx_state_e   state_reg;
  logic [5:0]              cnt_reg;
  logic                    cur_left_reg;
  logic                    ws_prev_reg;
  logic                    ws_m_reg;
  logic [5:0]              m_cnt_reg;
  logic                    bclk_m_reg;
  logic [7:0]              div_reg;
  logic                    m_fall_reg;
  logic                    first_reg;
  logic                    s_fall;
  logic                    s_ws;
  logic [2:0]              en;
  logic                    master;
  logic                    pol;
  logic                    ind_rst;
  logic                    clr_cond;
  logic [5:0]              len;
  logic                    fall;
  logic                    ws_m_next;
  logic                    ws_now;
  logic                    ws_edge;
  logic                    is_left;
  logic                    done;
  logic                    seek_l;
  logic                    seek_r;
  logic                    start;
  logic                    wr_tx;
  logic [2:0]              wr_mask_next;
  logic                    wr_done;
  logic                    clr_by_wr;
  logic                    set_l;
  logic                    set_r;

  shift_ctl_if sh ();

  assign en      = ctrl_reg[tx_seq_pkg::EN_LSB +: tx_seq_pkg::NUM_TX];
  assign master  = ctrl_reg[tx_seq_pkg::MASTER_BIT];
  assign pol     = ctrl_reg[tx_seq_pkg::POL_BIT];
  assign ind_rst = stop_state_in || (en == 3'h0);
  assign clr_cond = soft_rst_in || ind_rst;

  always_comb begin
    case (ctrl_reg[tx_seq_pkg::WL_LSB +: 2])
      tx_seq_pkg::WL_16: len = tx_seq_pkg::LEN_16;
      tx_seq_pkg::WL_24: len = tx_seq_pkg::LEN_24;
      tx_seq_pkg::WL_32: len = tx_seq_pkg::LEN_32;
      default:           len = tx_seq_pkg::LEN_24;
    endcase
  end

  link_sync u_bclk_sync (
    .clk_in    (ref_clk_in),
    .rst_in    (sys_rst_in),
    .pin_in    (bit_clk_in),
    .level_out (),
    .fall_out  (s_fall)
  );

  link_sync u_ws_sync (
    .clk_in    (ref_clk_in),
    .rst_in    (sys_rst_in),
    .pin_in    (word_sel_in),
    .level_out (s_ws),
    .fall_out  ()
  );

  // Master bit clock divider, held in individual reset so the left slot follows enabling.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !master || ind_rst) begin
      div_reg    <= 8'h00;
      bclk_m_reg <= 1'b1;
      m_fall_reg <= 1'b0;
    end else if (div_reg == HALF_DIV - 8'h01) begin
      div_reg    <= 8'h00;
      bclk_m_reg <= !bclk_m_reg;
      m_fall_reg <= bclk_m_reg;
    end else begin
      div_reg    <= div_reg + 8'h01;
      m_fall_reg <= 1'b0;
    end
  end

  assign fall = (master ? m_fall_reg : s_fall) && !ind_rst;

  // Master word select toggles every word length; it rests on the right and goes left at the first fall.
  always_comb begin
    ws_m_next = ws_m_reg;
    if (fall && m_cnt_reg == 6'h00) begin
      ws_m_next = !ws_m_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || ind_rst || state_reg == tx_seq_pkg::ST_IDLE) begin
      ws_m_reg  <= !pol;
      m_cnt_reg <= 6'h00;
    end else if (fall) begin
      ws_m_reg  <= ws_m_next;
      m_cnt_reg <= (m_cnt_reg == 6'h00) ? len - 6'h01 : m_cnt_reg - 6'h01;
    end
  end

  assign ws_now  = master ? ws_m_next : s_ws;
  assign ws_edge = fall && (ws_now != ws_prev_reg);
  assign is_left = !(ws_now ^ pol);
  assign done    = (state_reg == tx_seq_pkg::ST_SHIFT) && (cnt_reg == len);
  assign seek_l  = (state_reg == tx_seq_pkg::ST_WAIT_L) || (done && !cur_left_reg);
  assign seek_r  = (state_reg == tx_seq_pkg::ST_WAIT_R) || (done && cur_left_reg);
  assign start   = ws_edge && ((seek_l && is_left) || (seek_r && !is_left));

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ws_prev_reg <= 1'b0;
    end else if (ind_rst || state_reg == tx_seq_pkg::ST_IDLE) begin
      ws_prev_reg <= master ? !pol : s_ws;
    end else if (fall) begin
      ws_prev_reg <= ws_now;
    end
  end

  // Word sequencer.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || ind_rst) begin
      state_reg    <= tx_seq_pkg::ST_IDLE;
      cnt_reg      <= 6'h00;
      cur_left_reg <= 1'b0;
    end else begin
      case (state_reg)
        tx_seq_pkg::ST_IDLE: begin
          state_reg <= tx_seq_pkg::ST_WAIT_L;
        end
        tx_seq_pkg::ST_WAIT_L,
        tx_seq_pkg::ST_WAIT_R,
        tx_seq_pkg::ST_SHIFT: begin
          if (start) begin
            state_reg    <= tx_seq_pkg::ST_SHIFT;
            cnt_reg      <= 6'h01;
            cur_left_reg <= is_left;
          end else if (fall && done) begin
            state_reg <= cur_left_reg ? tx_seq_pkg::ST_WAIT_R
                                      : tx_seq_pkg::ST_WAIT_L;
          end else if (fall && state_reg == tx_seq_pkg::ST_SHIFT) begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= tx_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign sh.load   = start;
  assign sh.shift  = fall && (state_reg == tx_seq_pkg::ST_SHIFT) && !done && !start;
  assign sh.active = (state_reg == tx_seq_pkg::ST_SHIFT) || start;

  for (genvar i = 0; i < tx_seq_pkg::NUM_TX; i++) begin : g_tx
    tx_shifter u_shift (
      .clk_in    (ref_clk_in),
      .rst_in    (sys_rst_in),
      .ctl       (sh),
      .enable_in (en[i]),
      .data_in   (hold_reg[i]),
      .sdo_out   (serial_data_out[i])
    );
  end

  // Register writes; holding registers accept data in any state.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || soft_rst_in) begin
      ctrl_reg <= tx_seq_pkg::CTRL_RESET;
    end else if (wr_in && addr_in == tx_seq_pkg::ADDR_CTRL) begin
      ctrl_reg <= wdata_in & tx_seq_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < tx_seq_pkg::NUM_TX; i++) begin
        hold_reg[i] <= 24'h000000;
      end
    end else if (wr_tx) begin
      hold_reg[addr_in - tx_seq_pkg::ADDR_TX0] <= wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= 24'h000000;
    end else if (rd_in && addr_in == tx_seq_pkg::ADDR_CTRL) begin
      rdata_out <= (ctrl_reg & tx_seq_pkg::CTRL_WMASK)
                 | ({23'h000000, left_empty_reg} << tx_seq_pkg::LEFT_E_BIT)
                 | ({23'h000000, right_empty_reg} << tx_seq_pkg::RIGHT_E_BIT);
    end else if (rd_in) begin
      rdata_out <= hold_reg[addr_in - tx_seq_pkg::ADDR_TX0];
    end else begin
      rdata_out <= 24'h000000;
    end
  end

  // Empty flags and the clearing handshake.
  assign wr_tx        = wr_in && (addr_in != tx_seq_pkg::ADDR_CTRL);
  assign wr_mask_next = wr_mask_reg | (wr_tx ? 3'h1 << (addr_in - 2'h1) : 3'h0);
  assign wr_done      = wr_tx && ((wr_mask_next & en) == en);
  assign clr_by_wr    = wr_done && ((left_empty_reg ^ right_empty_reg)
                        || armed_reg);
  assign set_l        = start && !is_left;
  assign set_r        = start && is_left;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || clr_cond) begin
      left_empty_reg  <= 1'b0;
      right_empty_reg <= 1'b0;
    end else begin
      left_empty_reg  <= set_l || (left_empty_reg && !clr_by_wr);
      right_empty_reg <= set_r || (right_empty_reg && !clr_by_wr);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || clr_cond || set_l || set_r || clr_by_wr) begin
      wr_mask_reg <= 3'h0;
    end else if (rd_in && addr_in == tx_seq_pkg::ADDR_CTRL
                 && left_empty_reg && right_empty_reg) begin
      wr_mask_reg <= 3'h0;
    end else begin
      wr_mask_reg <= wr_mask_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || clr_cond || clr_by_wr) begin
      armed_reg <= 1'b0;
    end else if (rd_in && addr_in == tx_seq_pkg::ADDR_CTRL
                 && left_empty_reg && right_empty_reg) begin
      armed_reg <= 1'b1;
    end
  end

  // Interrupt request and vector.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_req_out    <= 1'b0;
      irq_vector_out <= tx_seq_pkg::VEC_BASE_LO;
    end else begin
      irq_req_out <= ctrl_reg[tx_seq_pkg::IE_BIT]
                     && (left_empty_reg || right_empty_reg);
      irq_vector_out <= (ctrl_reg[tx_seq_pkg::VLOC_BIT] ? tx_seq_pkg::VEC_BASE_HI
                                                        : tx_seq_pkg::VEC_BASE_LO)
                      + ((left_empty_reg && right_empty_reg) ? tx_seq_pkg::VEC_OFS_X
                         : right_empty_reg ? tx_seq_pkg::VEC_OFS_R
                         : tx_seq_pkg::VEC_OFS_L);
    end
  end

  // Link pin drivers; enables are low while this end drives.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bit_clk_out       <= 1'b1;
      bit_clk_oe_n_out  <= 1'b1;
      word_sel_out      <= 1'b0;
      word_sel_oe_n_out <= 1'b1;
    end else begin
      bit_clk_out       <= bclk_m_reg;
      bit_clk_oe_n_out  <= !master;
      word_sel_out      <= ws_m_reg;
      word_sel_oe_n_out <= !master;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || ind_rst) begin
      first_reg <= 1'b1;
    end else if (start) begin
      first_reg <= 1'b0;
    end
  end

  a_flags_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (en == 3'h0) |=> !left_empty_reg && !right_empty_reg)
    else $error("empty flag set while all transmitters disabled");
  a_left_first: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    start && first_reg |-> is_left)
    else $error("first word after enable was not left");
  a_left_sets_re: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    set_r && !clr_cond |=> right_empty_reg)
    else $error("left transfer did not set right-empty");
  a_right_sets_le: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    set_l && !clr_cond |=> left_empty_reg)
    else $error("right transfer did not set left-empty");
  a_bit13_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    rd_in && addr_in == tx_seq_pkg::ADDR_CTRL |=> !rdata_out[13])
    else $error("reserved bit read as one");
  a_underrun_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    left_empty_reg && right_empty_reg && !armed_reg && !clr_cond |=>
    left_empty_reg && right_empty_reg)
    else $error("underrun cleared without status read");
  a_single_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (left_empty_reg ^ right_empty_reg) && wr_done && !start |=>
    !left_empty_reg && !right_empty_reg)
    else $error("single empty flag not cleared by writes");
  a_set_wins: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    start && wr_done && !clr_cond |=> left_empty_reg || right_empty_reg)
    else $error("flag set lost to same-cycle write");
  a_word_bound: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    state_reg == tx_seq_pkg::ST_SHIFT |-> cnt_reg <= len)
    else $error("bit count passed word length");
  a_exc_vector: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    left_empty_reg && right_empty_reg && ctrl_reg[tx_seq_pkg::IE_BIT] |=>
    irq_req_out && irq_vector_out[3:0] == 4'h4)
    else $error("underrun did not raise exception vector");
  a_vec_base: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    irq_req_out |-> irq_vector_out[7:4] ==
    ($past(ctrl_reg[tx_seq_pkg::VLOC_BIT]) ? 4'h4 : 4'h1))
    else $error("vector base does not follow select bit");

  c_underrun: cover property (@(posedge ref_clk_in) left_empty_reg && right_empty_reg);
  c_master_load: cover property (@(posedge ref_clk_in) start && master);
  c_slave_load: cover property (@(posedge ref_clk_in) start && !master);
  c_long_word: cover property (@(posedge ref_clk_in) done && len == tx_seq_pkg::LEN_32);
endmodule // audio_serial_tx_status_sequencer

// file: tx_seq_pkg.sv
// Shared constants and types for the serial audio transmit sequencer.
package tx_seq_pkg;
  localparam int          DATA_W       = 24;
  localparam int          ADDR_W       = 2;
  localparam int          NUM_TX       = 3;
  localparam int          CNT_W        = 6;
  localparam int          DIV_W        = 8;
  localparam logic [7:0]  HALF_DIV     = 8'h04;
  localparam logic [1:0]  ADDR_CTRL    = 2'h0;
  localparam logic [1:0]  ADDR_TX0     = 2'h1;
  localparam int          EN_LSB       = 0;
  localparam int          MASTER_BIT   = 3;
  localparam int          WL_LSB       = 4;
  localparam int          POL_BIT      = 7;
  localparam int          IE_BIT       = 11;
  localparam int          VLOC_BIT     = 12;
  localparam int          LEFT_E_BIT   = 14;
  localparam int          RIGHT_E_BIT  = 15;
  localparam logic [23:0] CTRL_WMASK   = 24'h0018bf;
  localparam logic [23:0] CTRL_RESET   = 24'h000000;
  localparam logic [1:0]  WL_16        = 2'h0;
  localparam logic [1:0]  WL_24        = 2'h1;
  localparam logic [1:0]  WL_32        = 2'h2;
  localparam logic [5:0]  LEN_16       = 6'h10;
  localparam logic [5:0]  LEN_24       = 6'h18;
  localparam logic [5:0]  LEN_32       = 6'h20;
  localparam logic [7:0]  VEC_BASE_LO  = 8'h10;
  localparam logic [7:0]  VEC_BASE_HI  = 8'h40;
  localparam logic [7:0]  VEC_OFS_L    = 8'h00;
  localparam logic [7:0]  VEC_OFS_R    = 8'h02;
  localparam logic [7:0]  VEC_OFS_X    = 8'h04;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_WAIT_L = 4'h2,
    ST_WAIT_R = 4'h4,
    ST_SHIFT  = 4'h8
  } tx_state_e;
endpackage

// file: shift_ctl_if.sv
// Control strobes from the sequencer to the transmit shifters.
interface shift_ctl_if;
  logic load;
  logic shift;
  logic active;
  modport ctrl (output load, output shift, output active);
  modport unit (input load, input shift, input active);
endinterface

// file: link_sync.sv
// Three-stage synchroniser with filtered level and falling-edge pulses.
module link_sync (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Asynchronous input and results.
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // The level moves only once stages two and three agree.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
      fall_out  <= 1'b0;
    end else begin
      fall_out <= (s2_reg == s3_reg) && level_out && !s3_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // link_sync

// file: tx_shifter.sv
// One transmit shift register; after 24 bits it repeats its last bit.
module tx_shifter (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Control and data.
  shift_ctl_if.unit        ctl,
  input  wire logic        enable_in,
  input  wire logic [23:0] data_in,
  output logic             sdo_out
);
  logic [23:0] sr_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sr_reg <= 24'h000000;
    end else if (ctl.load) begin
      sr_reg <= data_in;
    end else if (ctl.shift) begin
      sr_reg <= {sr_reg[22:0], sr_reg[0]};
    end
  end

  // A disabled transmitter or a gap between words holds the line high.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sdo_out <= 1'b1;
    end else begin
      sdo_out <= (ctl.active && enable_in) ? sr_reg[23] : 1'b1;
    end
  end
endmodule // tx_shifter

// file: codec_model.sv
// Slave-side link partner: makes bit clock and word select, captures transmitter 0.
module codec_model (
  // Control from the bench.
  input  wire logic  run_in,
  // Serial data from transmitter 0.
  input  wire logic  sdo_in,
  // Link clock and framing.
  output logic       bclk_out,
  output logic       ws_out,
  // Last word captured per channel.
  output logic [23:0] left_word_out,
  output logic [23:0] right_word_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] cap;
  int          cnt;
  // The clock only runs while a frame stream is wanted, otherwise it rests high.
  initial begin
    bclk_out = 1'b1;
    ws_out = 1'b1;
    cnt = 23;
    cap = 24'h000000;
    left_word_out = 24'h000000;
    right_word_out = 24'h000000;
    #13;
    forever begin
      #160;
      bclk_out = run_in ? ~bclk_out : 1'b1;
    end
  end
  // Bits are taken at the falling edge, before the transmitter moves to the next bit.
  always @(negedge bclk_out) begin
    cap = {cap[22:0], sdo_in};
    if (cnt == 23) begin
      if (ws_out) right_word_out = cap;
      else left_word_out = cap;
      ws_out = ~ws_out;
      cnt = 0;
    end else begin
      cnt++;
    end
  end
endmodule // codec_model

// file: tb.sv
// Self-checking bench for the serial audio transmit sequencer.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] L0 = 24'ha5c3e1;
  localparam logic [23:0] R0 = 24'h3c5a96;
  localparam logic [23:0] L1 = 24'h0f1e2d;
  localparam logic [23:0] U  = 24'h7b6d59;
  logic        clk, rst, soft_rst, stop_st, wr, rd, run, bclk, ws, irq;
  logic [1:0]  addr;
  logic [23:0] wdata, rdata, lw, rw, d;
  logic [7:0]  vec;
  logic [2:0]  sdo;
  logic        bclk_m, bclk_oe_n, ws_m, ws_oe_n;
  int          n_fail, tests_run;
  int          cycles = 0;

  initial clk = 1'b0;
  always #20 clk = ~clk;

  audio_serial_tx_status_sequencer #(.HALF_DIV(tx_seq_pkg::HALF_DIV)) dut_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .soft_rst_in(soft_rst), .stop_state_in(stop_st),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .irq_req_out(irq), .irq_vector_out(vec), .bit_clk_in(bclk), .word_sel_in(ws),
    .bit_clk_out(bclk_m), .bit_clk_oe_n_out(bclk_oe_n), .word_sel_out(ws_m),
    .word_sel_oe_n_out(ws_oe_n),
    .serial_data_out(sdo));

  codec_model codec_u (.run_in(run), .sdo_in(sdo[0]), .bclk_out(bclk), .ws_out(ws),
    .left_word_out(lw), .right_word_out(rw));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [23:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [23:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Holding register 0 gets v itself, the others a variant of it.
  task automatic wr_all(input logic [23:0] v);
    for (int i = 1; i < 4; i++) reg_wr(2'(i), v ^ 24'(i - 1));
  endtask

  task automatic wait_vec(input logic [7:0] v, input bit any);
    int k;
    k = 0;
    while (!(irq === 1'b1 && (any || vec === v)) && k < 600) begin
      @(posedge clk);
      k++;
    end
    chk("irq_req", 32'h1, 32'(irq));
    if (!any) chk("irq_vector", 32'(v), 32'(vec));
  endtask

  task automatic t_reset();
    reg_rd(2'h0, d);
    chk("status", 32'h0, 32'(d));
    chk("irq_vector", 32'h10, 32'(vec));
    chk("serial_data", 32'h7, 32'(sdo));
  endtask

  task automatic t_stream();
    wr_all(L0);
    reg_wr(2'h0, 24'h000817);
    run <= 1'b1;
    wait_vec(8'h12, 1'b0);
    wr_all(R0);
    reg_rd(2'h0, d);
    chk("status", 32'h000817, 32'(d));
    chk("irq_req", 32'h0, 32'(irq));
    wait_vec(8'h10, 1'b0);
    chk("left word", 32'(L0), 32'(lw));
    wr_all(L1);
    wait_vec(8'h12, 1'b0);
    chk("right word", 32'(R0), 32'(rw));
  endtask

  task automatic t_underrun();
    reg_wr(2'h0, 24'h001817);
    wait_vec(8'h44, 1'b0);
    wr_all(U);
    chk("irq_vector", 32'h44, 32'(vec));
    reg_rd(2'h0, d);
    chk("status", 32'h00d817, 32'(d));
    wr_all(U);
    reg_rd(2'h0, d);
    chk("status", 32'h001817, 32'(d));
    wait_vec(8'h42, 1'b0);
    chk("right word", 32'(L1), 32'(rw));
  endtask

  task automatic t_stop_disable();
    stop_st <= 1'b1;
    @(posedge clk);
    reg_rd(2'h0, d);
    chk("status", 32'h001817, 32'(d));
    stop_st <= 1'b0;
    wait_vec(8'h00, 1'b1);
    reg_wr(2'h0, 24'h001810);
    stop_st <= 1'b1;
    @(posedge clk);
    stop_st <= 1'b0;
    reg_rd(2'h0, d);
    chk("status", 32'h001810, 32'(d));
    chk("serial_data", 32'h7, 32'(sdo));
  endtask

  task automatic t_soft();
    run <= 1'b0;
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    reg_rd(2'h0, d);
    chk("status", 32'h0, 32'(d));
    reg_rd(2'h1, d);
    chk("holding 0", 32'(U), 32'(d));
    reg_wr(2'h0, 24'hfffff8);
    reg_rd(2'h0, d);
    chk("status", 32'h0018b8, 32'(d));
    reg_wr(2'h0, 24'h000000);
  endtask

  // Master mode with 16-bit words and interrupts off: poll right-empty, then catch a right word.
  task automatic t_master();
    int          k;
    logic [15:0] c1, c2;
    wr_all(L1);
    reg_wr(2'h0, 24'h00000f);
    k = 0;
    do begin
      reg_rd(2'h0, d);
      k++;
    end while (!d[15] && k < 40);
    chk("status", 32'h00800f, 32'(d));
    chk("link drive", 32'h0, 32'({bclk_oe_n, ws_oe_n}));
    wr_all(R0);
    reg_rd(2'h0, d);
    chk("status", 32'h00000f, 32'(d));
    chk("irq_req", 32'h0, 32'(irq));
    @(posedge ws_m);
    for (int i = 0; i < 16; i++) begin
      @(posedge bclk_m);
      c1 = {c1[14:0], sdo[1]};
      c2 = {c2[14:0], sdo[2]};
    end
    chk("tx1 word", 32'(R0[23:8]), 32'(c1));
    chk("tx2 word", 32'(R0[23:8]), 32'(c2));
    reg_wr(2'h0, 24'h000000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    {rst, soft_rst, stop_st, wr, rd, run} = 6'b100000;
    addr = 2'h0;
    wdata = 24'h000000;
    n_fail = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_stream();
    t_underrun();
    t_stop_disable();
    t_soft();
    t_master();
    report_and_stop();
  end
endmodule // tb
